/* cpdp_data_path.v */
// Overview of operation
// - The link presents transmit data on 2, 4 or 8 lines per speed; it is latched on the system clock.
// - Latched bits are serialized and data-strobe encoded at the S100, S200 or S400 bit rate.
// - While transmitting, encoded data goes out on TPB and encoded strobe on TPA of each connected port.
// - A receiving port has both its drivers disabled and its receivers enabled.
// - On reception data is taken from TPA and strobe from TPB.
// - The incoming data-strobe pair is decoded into a bit clock and serial bits.
// - Received bits are grouped to 2, 4 or 8 lines per speed and resynchronized to the system clock.
// - Data received on one port is repeated onto every other active, connected port.
// - A system clock is driven to the link and also times the received-data resync.
// - The multiplied bit reference is divided internally to time the outbound data and strobe.
// - Driving the power-down input high stops the clock generator.
// - With the barrier select high the link outputs are driven in plain form.
// - With the barrier select low the received data and valid outputs are differentiated for an isolation barrier.
// - Line-state comparators give arbitration status; TPA common mode sets the next packet speed.
// - TPB common-mode bias detection marks the remote node as connected.
`timescale 1ns/10ps
`default_nettype none
`include "cpdp_defs.vh"

module cpdp_data_path #(
    parameter NPORT = 2
) (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // Mode pins
    input wire power_down_input,
    input wire barrier_sel,
    // Link transmit request
    input wire tx_req,
    input wire [1:0] tx_speed,
    input wire [7:0] tx_data,
    // Link receive delivery and clock
    output reg sys_clk_q,
    output reg [7:0] rx_data_q,
    output reg rx_valid_q,
    output reg [1:0] rx_speed_q,
    // Cable pairs
    output wire [NPORT-1:0] tpa_out,
    output wire [NPORT-1:0] tpa_oe,
    output wire [NPORT-1:0] tpb_out,
    output wire [NPORT-1:0] tpb_oe,
    input wire [NPORT-1:0] tpa_in,
    input wire [NPORT-1:0] tpb_in,
    // Line sensing
    input wire [2*NPORT-1:0] tpa_cmp,
    input wire [2*NPORT-1:0] tpb_cmp,
    input wire [2*NPORT-1:0] tpa_cm_speed,
    input wire [NPORT-1:0] tpb_bias_det,
    // Status
    output reg pll_run_q,
    output reg [4*NPORT-1:0] arb_status_q,
    output reg [NPORT-1:0] conn_q,
    output reg [NPORT-1:0] port_rx_q
);

    // Lane count for a speed code
    function [3:0] lanes;
        input [1:0] spd;
        begin
            case (spd)
                `CPDP_SPD_S100: lanes = `CPDP_LANES_S100;
                `CPDP_SPD_S200: lanes = `CPDP_LANES_S200;
                default: lanes = `CPDP_LANES_S400;
            endcase
        end
    endfunction

    // Bit tick for a speed code: divider taps on the slot counter
    function tick_at;
        input [1:0] spd;
        input [2:0] slot;
        begin
            case (spd)
                `CPDP_SPD_S100: tick_at = (slot & `CPDP_TICK_S100) == 3'h0;
                `CPDP_SPD_S200: tick_at = (slot & `CPDP_TICK_S200) == 3'h0;
                default: tick_at = (slot & `CPDP_TICK_S400) == 3'h0;
            endcase
        end
    endfunction

    reg [2:0] slot_q;
    reg tx_busy_q;
    reg [1:0] tx_spd_q;
    reg [7:0] tx_shift_q;
    reg [3:0] tx_left_q;
    reg [7:0] des_q;
    reg [3:0] des_cnt_q;
    reg [7:0] hold_q;
    reg pend_q;
    reg [7:0] word_raw_q;
    reg valid_raw_q;
    reg [7:0] word_d;
    reg valid_d;
    reg [NPORT-1:0] port_tx_en;
    reg [NPORT-1:0] port_tick;
    reg [NPORT-1:0] port_bit;
    reg [NPORT-1:0] port_rx_d;
    reg [1:0] rx_speed_d;
    reg rx_bit;
    reg rx_vld;
    wire [NPORT-1:0] rx_bit_w;
    wire [NPORT-1:0] rx_vld_w;
    wire slot0;
    wire tx_tick;
    wire word_done;
    wire [7:0] des_next;
    integer p, q;
    genvar g;

    assign slot0 = slot_q == 3'h0;
    assign tx_tick = tx_busy_q & tick_at(tx_spd_q, slot_q) & (tx_left_q != 4'h0);
    assign des_next = {des_q[6:0], rx_bit};
    assign word_done = rx_vld & ((des_cnt_q + 4'h1) == lanes(rx_speed_q));

    // Clock generator: stops on power-down, slot counter divides the bit reference
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_run_q <= 1'b0;
            slot_q <= 3'h0;
            sys_clk_q <= 1'b0;
        end else begin
            pll_run_q <= ~power_down_input;
            if (pll_run_q) begin
                slot_q <= slot_q + 3'h1;
            end else begin
                slot_q <= 3'h0; // Restart keeps the first link clock period whole
            end
            sys_clk_q <= pll_run_q & slot_q[`CPDP_SLOT_HALF_BIT];
        end
    end

    // Transmit latch and serializer, one word per system clock period
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_busy_q <= 1'b0;
            tx_spd_q <= `CPDP_SPD_S100;
            tx_shift_q <= 8'h00;
            tx_left_q <= 4'h0;
        end else if (!pll_run_q) begin
            tx_busy_q <= 1'b0;
            tx_left_q <= 4'h0;
        end else if (slot0) begin
            // A packet being received owns the ports; the link must wait
            tx_busy_q <= tx_req & ~(|port_rx_q);
            tx_spd_q <= tx_speed;
            tx_shift_q <= tx_data;
            tx_left_q <= (tx_req & ~(|port_rx_q)) ? lanes(tx_speed) : 4'h0;
        end else if (tx_tick) begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
            tx_left_q <= tx_left_q - 4'h1;
        end
    end

    // Connection, arbitration sensing and receive port selection
    always @* begin
        port_rx_d = port_rx_q;
        rx_speed_d = rx_speed_q;
        for (p = 0; p < NPORT; p = p + 1) begin
            if (port_rx_q[p] && tpa_cmp[2*p +: 2] == `CPDP_LS_IDLE &&
                tpb_cmp[2*p +: 2] == `CPDP_LS_IDLE) begin
                port_rx_d[p] = 1'b0;
            end
        end
        for (p = NPORT - 1; p >= 0; p = p - 1) begin
            if (port_rx_q == {NPORT{1'b0}} && !tx_busy_q && conn_q[p] &&
                tpb_cmp[2*p +: 2] == `CPDP_LS_PREFIX) begin
                port_rx_d = {NPORT{1'b0}};
                port_rx_d[p] = 1'b1;
                rx_speed_d = tpa_cm_speed[2*p +: 2];
            end
        end
        if (!pll_run_q) begin
            port_rx_d = {NPORT{1'b0}};
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conn_q <= {NPORT{1'b0}};
            arb_status_q <= {4*NPORT{1'b0}};
            port_rx_q <= {NPORT{1'b0}};
            rx_speed_q <= `CPDP_SPD_S100;
        end else begin
            conn_q <= tpb_bias_det;
            arb_status_q <= {tpa_cmp, tpb_cmp};
            port_rx_q <= port_rx_d;
            rx_speed_q <= rx_speed_d;
        end
    end

    // Per-port source: link serializer, or the other port's recovered stream
    always @* begin
        rx_bit = 1'b0;
        rx_vld = 1'b0;
        for (q = 0; q < NPORT; q = q + 1) begin
            if (port_rx_q[q]) begin
                rx_bit = rx_bit_w[q];
                rx_vld = rx_vld_w[q];
            end
        end
        for (q = 0; q < NPORT; q = q + 1) begin
            if (tx_busy_q) begin
                port_tx_en[q] = conn_q[q] & ~port_rx_q[q] & pll_run_q;
                port_tick[q] = tx_tick;
                port_bit[q] = tx_shift_q[7];
            end else begin
                port_tx_en[q] = (|port_rx_q) & ~port_rx_q[q] & conn_q[q] & pll_run_q;
                port_tick[q] = rx_vld;
                port_bit[q] = rx_bit;
            end
        end
    end

    generate
        for (g = 0; g < NPORT; g = g + 1) begin : g_port
            cpdp_ds_port u_port (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .tx_en(port_tx_en[g]),
                .tx_tick(port_tick[g]),
                .tx_bit(port_bit[g]),
                .rx_en(port_rx_q[g]),
                .rx_data_in(tpa_in[g]),
                .rx_strb_in(tpb_in[g]),
                .rx_bit_q(rx_bit_w[g]),
                .rx_bit_vld_q(rx_vld_w[g]),
                .tpa_out_q(tpa_out[g]),
                .tpa_oe_q(tpa_oe[g]),
                .tpb_out_q(tpb_out[g]),
                .tpb_oe_q(tpb_oe[g])
            );
        end
    endgenerate

    // Deserializer: first received bit lands in bit 7
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            des_q <= 8'h00;
            des_cnt_q <= 4'h0;
            hold_q <= 8'h00;
            pend_q <= 1'b0;
        end else begin
            if (!(|port_rx_q)) begin
                des_cnt_q <= 4'h0;
            end else if (word_done) begin
                des_cnt_q <= 4'h0;
                hold_q <= des_next << (4'h8 - lanes(rx_speed_q));
            end else if (rx_vld) begin
                des_q <= des_next;
                des_cnt_q <= des_cnt_q + 4'h1;
            end
            // A word finishing on the delivery slot stays pending
            pend_q <= word_done | (pend_q & ~slot0);
        end
    end

    // Resync onto system clock slots, then plain or differentiated drive
    always @* begin
        word_d = word_raw_q;
        valid_d = valid_raw_q;
        if (slot0) begin
            word_d = pend_q ? hold_q : 8'h00;
            valid_d = pend_q;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_raw_q <= 8'h00;
            valid_raw_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            word_raw_q <= word_d;
            valid_raw_q <= valid_d;
            if (barrier_sel) begin
                rx_data_q <= word_d;
                rx_valid_q <= valid_d;
            end else begin
                // Only edges cross a capacitive barrier, so send change pulses
                rx_data_q <= word_d ^ word_raw_q;
                rx_valid_q <= valid_d ^ valid_raw_q;
            end
        end
    end

endmodule // cpdp_data_path

`default_nettype wire

/* cpdp_defs.vh */
`ifndef CPDP_DEFS_VH
`define CPDP_DEFS_VH

// Clock plan in kHz: reference, multiplied bit reference, link system clock
`define CPDP_REF_KHZ 24576
`define CPDP_PLL_KHZ 393216
`define CPDP_SYS_KHZ 49152
// Core cycles (one S400 bit each) per system clock period, and PLL factor
`define CPDP_SLOT_CYC (`CPDP_PLL_KHZ / `CPDP_SYS_KHZ)
`define CPDP_PLL_MULT (`CPDP_PLL_KHZ / `CPDP_REF_KHZ)
// Serial rates in kbit/s
`define CPDP_S100_KBPS 98304
`define CPDP_S200_KBPS 196608
`define CPDP_S400_KBPS 393216

// Speed codes, shared by the link side and the sensed common-mode level
`define CPDP_SPD_S100 2'h0
`define CPDP_SPD_S200 2'h1
`define CPDP_SPD_S400 2'h2

// Parallel lane counts per speed
`define CPDP_LANES_S100 4'h2
`define CPDP_LANES_S200 4'h4
`define CPDP_LANES_S400 4'h8

// Bit tick masks on the slot counter per speed
`define CPDP_TICK_S100 3'h3
`define CPDP_TICK_S200 3'h1
`define CPDP_TICK_S400 3'h0

// Line-state comparator codes
`define CPDP_LS_IDLE 2'h0
`define CPDP_LS_PREFIX 2'h1

// Half of the slot counter range marks the high phase of the link clock
`define CPDP_SLOT_HALF_BIT 2

`endif

/* cpdp_ds_port.v */
`timescale 1ns/10ps
`default_nettype none

// One cable port: data-strobe encoder toward the pairs, decoder from them
module cpdp_ds_port (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // Transmit side
    input wire tx_en,
    input wire tx_tick,
    input wire tx_bit,
    // Receive side
    input wire rx_en,
    input wire rx_data_in,
    input wire rx_strb_in,
    output reg rx_bit_q,
    output reg rx_bit_vld_q,
    // Cable pair drivers
    output reg tpa_out_q,
    output reg tpa_oe_q,
    output reg tpb_out_q,
    output reg tpb_oe_q
);

    reg prev_par_q;
    wire rx_par;

    assign rx_par = rx_data_in ^ rx_strb_in;

    // Encoder: data on TPB, strobe on TPA toggles when data repeats
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tpa_out_q <= 1'b0;
            tpb_out_q <= 1'b0;
            tpa_oe_q <= 1'b0;
            tpb_oe_q <= 1'b0;
        end else begin
            tpa_oe_q <= tx_en & ~rx_en;
            tpb_oe_q <= tx_en & ~rx_en;
            if (!tx_en) begin
                // Idle lines at zero so the far decoder starts from even parity
                tpa_out_q <= 1'b0;
                tpb_out_q <= 1'b0;
            end else if (tx_tick) begin
                tpb_out_q <= tx_bit;
                if (tx_bit == tpb_out_q) begin
                    tpa_out_q <= ~tpa_out_q;
                end
            end
        end
    end

    // Decoder: every parity change of data^strobe is one recovered bit
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_par_q <= 1'b0;
            rx_bit_q <= 1'b0;
            rx_bit_vld_q <= 1'b0;
        end else if (!rx_en) begin
            prev_par_q <= 1'b0;
            rx_bit_vld_q <= 1'b0;
        end else begin
            prev_par_q <= rx_par;
            rx_bit_vld_q <= rx_par != prev_par_q;
            if (rx_par != prev_par_q) begin
                rx_bit_q <= rx_data_in;
            end
        end
    end

endmodule // cpdp_ds_port

`default_nettype wire

/* cpdp_data_path_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the data path ports on the core clock
module cpdp_chk #(
    parameter NPORT = 2
) (
    // Clock, reset and mode pins
    input wire ref_clk,
    input wire sys_rst,
    input wire power_down_input,
    input wire barrier_sel,
    input wire tx_req,
    // Link side outputs
    input wire sys_clk_q,
    input wire rx_valid_q,
    input wire [1:0] rx_speed_q,
    input wire pll_run_q,
    // Cable side
    input wire [NPORT-1:0] tpa_oe,
    input wire [NPORT-1:0] tpb_oe,
    input wire [2*NPORT-1:0] tpa_cmp,
    input wire [2*NPORT-1:0] tpb_cmp,
    input wire [2*NPORT-1:0] tpa_cm_speed,
    input wire [NPORT-1:0] tpb_bias_det,
    input wire [4*NPORT-1:0] arb_status_q,
    input wire [NPORT-1:0] conn_q,
    input wire [NPORT-1:0] port_rx_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_rx_quiet;
        (port_rx_q & (tpa_oe | tpb_oe)) == '0;
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("receiving port drives");
    property p_rx_start;
        pll_run_q && !tx_req && conn_q[0] && tpb_cmp[1:0] == 2'h1 && port_rx_q == '0
            |=> port_rx_q[0];
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("receive not started");
    property p_pair_oe;
        tpa_oe == tpb_oe;
    endproperty
    a_pair_oe: assert property (p_pair_oe) else $error("pair enables differ");
    property p_pll_stop;
        power_down_input |=> !pll_run_q;
    endproperty
    a_pll_stop: assert property (p_pll_stop) else $error("clock kept running");
    property p_clk_low;
        !pll_run_q && !$past(pll_run_q) |-> !sys_clk_q;
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("link clock not stopped");
    // Power-down may cut a period short, so it aborts the attempt
    property p_clk_period;
        disable iff (sys_rst || power_down_input)
        $rose(sys_clk_q) |-> sys_clk_q[*4] ##1 !sys_clk_q[*4];
    endproperty
    a_clk_period: assert property (p_clk_period) else $error("link clock period");
    property p_arb;
        !$past(sys_rst) |-> arb_status_q == $past({tpa_cmp, tpb_cmp});
    endproperty
    a_arb: assert property (p_arb) else $error("line state not tracked");
    property p_rx_speed;
        $rose(port_rx_q[0]) |-> rx_speed_q == $past(tpa_cm_speed[1:0]);
    endproperty
    a_rx_speed: assert property (p_rx_speed) else $error("receive speed wrong");
    property p_conn;
        !$past(sys_rst) |-> conn_q == $past(tpb_bias_det);
    endproperty
    a_conn: assert property (p_conn) else $error("connection not tracked");
    property p_valid_plain;
        barrier_sel && $rose(rx_valid_q) |-> rx_valid_q[*8];
    endproperty
    a_valid_plain: assert property (p_valid_plain) else $error("valid too short");
    property p_valid_pulse;
        !barrier_sel && rx_valid_q |=> !rx_valid_q;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid not a pulse");

    c_rx: cover property ($rose(port_rx_q[0]));
    c_tx: cover property ($rose(tpb_oe[0]));
    c_pd: cover property ($fell(pll_run_q));
endmodule // cpdp_chk

bind cpdp_data_path cpdp_chk #(.NPORT(NPORT)) i_cpdp_chk (.ref_clk, .sys_rst,
    .power_down_input, .barrier_sel, .tx_req, .sys_clk_q, .rx_valid_q, .rx_speed_q,
    .pll_run_q, .tpa_oe, .tpb_oe, .tpa_cmp, .tpb_cmp, .tpa_cm_speed, .tpb_bias_det,
    .arb_status_q, .conn_q, .port_rx_q);
`default_nettype wire

/* cpdp_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Link-side model: presents lanes and keeps the last received word
module cpdp_link_model (
    // Clock and bench commands
    input wire ref_clk,
    input wire send,
    input wire [1:0] spd,
    input wire [7:0] word,
    // Device side
    output logic tx_req,
    output logic [1:0] tx_speed,
    output logic [7:0] tx_data,
    input wire [7:0] rx_data_q,
    input wire rx_valid_q,
    output logic [7:0] rx_word,
    output int rx_cnt
);
    logic [7:0] mask;
    logic req_q = 1'b0;
    logic [1:0] spd_q = 2'h0;
    logic [7:0] dat_q = 8'h00;
    logic valid_q = 1'b0;
    logic [7:0] word_q = 8'h00;
    int cnt_q = 0;

    assign tx_req = req_q;
    assign tx_speed = spd_q;
    assign tx_data = dat_q;
    assign rx_word = word_q;
    assign rx_cnt = cnt_q;
    // Lanes in use per speed, from bit 7 down
    assign mask = spd == 2'h0 ? 8'hc0 : spd == 2'h1 ? 8'hf0 : 8'hff;
    // Unused lanes carry the inverse so stray use of them shows
    always @(negedge ref_clk) begin
        req_q <= send;
        spd_q <= spd;
        dat_q <= (word & mask) | (~word & ~mask);
    end
    // Takes a word when valid rises
    always @(posedge ref_clk) begin
        if (rx_valid_q && !valid_q) begin
            word_q <= rx_data_q;
            cnt_q <= cnt_q + 1;
        end
        valid_q <= rx_valid_q;
    end
endmodule // cpdp_link_model
`default_nettype wire

/* tb_cpdp_data_path.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpdp_defs.vh"
module tb_cpdp_data_path;
    logic ref_clk = 1'b0, sys_rst = 1'b1, power_down_input = 1'b0, barrier_sel = 1'b1;
    logic send = 1'b0, ds_q = 1'b0, tx_req, sys_clk_q, rx_valid_q, pll_run_q;
    logic [1:0] spd = 2'h2, tx_speed, rx_speed_q, tpa_out, tpa_oe, tpb_out, tpb_oe;
    logic [1:0] conn_q, port_rx_q, tpa_in = 2'h0, tpb_in = 2'h0, tpb_bias_det = 2'h3;
    logic [3:0] tpa_cmp = 4'h0, tpb_cmp = 4'h0, tpa_cm_speed = 4'h0;
    logic [7:0] word = 8'h9b, tx_data, rx_data_q, rx_word, arb_status_q, bits;
    int rx_cnt, failures = 0, check_count = 0, cyc = 0, mon_p = 0, bit_n = 0;
    int t_bit[2];

    cpdp_data_path #(.NPORT(2)) i_cpdp_data_path (.ref_clk, .sys_rst, .power_down_input,
        .barrier_sel, .tx_req, .tx_speed, .tx_data, .sys_clk_q, .rx_data_q, .rx_valid_q,
        .rx_speed_q, .tpa_out, .tpa_oe, .tpb_out, .tpb_oe, .tpa_in, .tpb_in, .tpa_cmp,
        .tpb_cmp, .tpa_cm_speed, .tpb_bias_det, .pll_run_q, .arb_status_q, .conn_q,
        .port_rx_q);
    cpdp_link_model i_cpdp_link_model (.ref_clk, .send, .spd, .word, .tx_req, .tx_speed,
        .tx_data, .rx_data_q, .rx_valid_q, .rx_word, .rx_cnt);

    initial forever #25 ref_clk = ~ref_clk;
    // Decodes the watched port: every change of data xor strobe is one bit
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if ((tpa_out[mon_p] ^ tpb_out[mon_p]) != ds_q && tpb_oe[mon_p] && bit_n < 8) begin
            bits[7 - bit_n] <= tpb_out[mon_p];
            if (bit_n < 2) t_bit[bit_n] <= cyc;
            bit_n <= bit_n + 1;
        end
        ds_q <= tpa_out[mon_p] ^ tpb_out[mon_p];
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic nclk(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic t_clock;
        int c0;
        nclk(4);
        chk(8'(pll_run_q), 8'h01);
        chk(8'(conn_q), 8'h03);
        @(posedge sys_clk_q);
        nclk(1);
        c0 = cyc;
        @(posedge sys_clk_q);
        nclk(1);
        chk(8'(cyc - c0), 8'h08);
    endtask
    // Sends repeated words; checks lane order, bit spacing and both ports driving
    task automatic t_tx(input logic [1:0] s, input int lanes, input int step);
        logic [7:0] m;
        m = 8'hff << (8 - lanes);
        mon_p = 0;
        bit_n = 0;
        spd = s;
        send = 1'b1;
        for (int i = 0; i < 80 && bit_n < lanes; i++) nclk(1);
        chk(8'(tpa_oe), 8'h03);
        send = 1'b0;
        chk(bits & m, word & m);
        chk(8'(t_bit[1] - t_bit[0]), 8'(step));
        nclk(30);
    endtask
    task automatic t_pd;
        power_down_input = 1'b1;
        nclk(2);
        send = 1'b1;
        nclk(10);
        chk(8'(pll_run_q), 8'h00);
        chk(8'(sys_clk_q), 8'h00);
        chk(8'(tpb_oe), 8'h00);
        send = 1'b0;
        power_down_input = 1'b0;
        nclk(12);
        chk(8'(pll_run_q), 8'h01);
    endtask
    // Receives one word on port 0; port 1 must repeat it
    task automatic t_rx(input logic [1:0] s, input int lanes, input int step, input logic sel);
        logic d, st, p;
        logic [7:0] m;
        int cnt0;
        m = 8'hff << (8 - lanes);
        p = 1'b0;
        st = 1'b0;
        barrier_sel = sel;
        mon_p = 1;
        bit_n = 0;
        tpa_cm_speed = {2'h0, s};
        tpb_cmp = 4'h1;
        nclk(2);
        chk(8'(port_rx_q), 8'h01);
        chk(8'(rx_speed_q), 8'(s));
        chk(arb_status_q, 8'h01);
        for (int i = 7; i > 7 - lanes; i--) begin
            d = word[i];
            if (d == p) st = ~st;
            tpa_in[0] = d;
            tpb_in[0] = st;
            p = d;
            nclk(step);
        end
        chk(8'(tpa_oe), 8'h02);
        for (int i = 0; i < 40 && rx_valid_q !== 1'b1; i++) nclk(1);
        cnt0 = rx_cnt;
        chk(8'(rx_valid_q), 8'h01);
        nclk(1);
        chk(8'(rx_valid_q), 8'(sel));
        chk(8'(rx_cnt - cnt0), 8'h01);
        chk(rx_word, word & m);
        chk(bits & m, word & m);
        tpb_cmp = 4'h0;
        nclk(2);
        tpa_in = 2'h0;
        tpb_in = 2'h0;
        nclk(16);
        // Direct drive returns only after the held slot value has drained
        barrier_sel = 1'b1;
    endtask

    // Cuts a hang short well beyond the expected run time
    initial begin
        #200000;
        failures++;
        end_sim();
    end
    initial begin
        nclk(2);
        sys_rst = 1'b0;
        t_clock();
        t_tx(`CPDP_SPD_S100, `CPDP_LANES_S100, 4);
        t_tx(`CPDP_SPD_S200, `CPDP_LANES_S200, 2);
        t_tx(`CPDP_SPD_S400, `CPDP_LANES_S400, 1);
        t_tx(2'h3, 8, 1);
        t_pd();
        word = 8'h6d;
        t_rx(`CPDP_SPD_S100, `CPDP_LANES_S100, 4, 1'b1);
        t_rx(`CPDP_SPD_S200, `CPDP_LANES_S200, 2, 1'b1);
        t_rx(`CPDP_SPD_S400, `CPDP_LANES_S400, 1, 1'b1);
        word = 8'hb2;
        t_rx(`CPDP_SPD_S400, `CPDP_LANES_S400, 1, 1'b0);
        end_sim();
    end
endmodule // tb_cpdp_data_path
`default_nettype wire
